// [hdl/mdc_coproc.sv]
// Multiply/divide/accumulate coprocessor with status and identification registers
`timescale 1ns/10ps
`include "mdc_consts.svh"
module mdc_coproc
    import mdc_pkg::*;
(
    input wire logic ref_clk, // Clock, 125 MHz
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic regWrite, // Coprocessor register write strobe
    input wire logic regRead, // Coprocessor register read strobe
    input wire logic [3:0] regIndex, // Coprocessor register number
    input wire logic [7:0] regWdata, // Write data
    output logic [7:0] regRdata_q, // Read data, valid cycle after read
    output logic calcBusy_q // Busy bit mirror
);
    typedef struct packed {
        logic [31:0] res;
        logic [31:0] opA;
        logic [15:0] opB;
        logic [7:0] setup;
        logic [7:0] status;
        logic [7:0] rdata;
        mdc_state_e state;
        logic [2:0] mulCnt;
        logic [2:0] runSel;
        logic runSigned;
        logic negQuo;
        logic negRem;
        logic divZero;
    } mdc_top_s;

    mdc_top_s s_q, s_d;

    // ****************************************
    // Arithmetic datapath
    // ****************************************
    logic signedSet, launch;
    logic [2:0] calcSelect;
    logic [16:0] aExt, bExt;
    logic [33:0] prodWide;
    logic [31:0] prod;
    logic [33:0] macSum;
    logic macCarry, macOvf, macSat;
    logic [31:0] macRes;
    logic [31:0] divDividend, divDivisor, quoMag, remMag, quoRes, remRes;
    logic [31:0] divisorRaw;
    logic [7:0] opBNow;
    logic divDone, divStart;
    logic [7:0] flagsNew;
    logic [31:0] finalRes;
    logic fCarry, fZero, fSign, fOvf, fSat;

    assign signedSet = s_q.setup[`MDC_SETUP_SIGNED];
    assign calcSelect = s_q.setup[2:0];

    assign aExt = {s_q.runSigned & s_q.opA[15], s_q.opA[15:0]};
    assign bExt = {s_q.runSigned & s_q.opB[15], s_q.opB};
    assign prodWide = $signed(aExt) * $signed(bExt);
    assign prod = prodWide[31:0];

    // Accumulator term is the previous result
    assign macSum = s_q.runSigned ?
        {{2{prod[31]}}, prod} + {{2{s_q.res[31]}}, s_q.res} :
        {2'b00, prod} + {2'b00, s_q.res};
    assign macCarry = macSum[32];
    assign macOvf = s_q.runSigned ? (macSum[32] != macSum[31]) :
        (prod[31] == s_q.res[31]) && (macSum[31] != prod[31]);
    assign macSat = s_q.runSigned ? macOvf : macCarry;
    always_comb begin
        macRes = macSum[31:0];
        if (s_q.runSel == MDC_MACSAT && macSat) begin
            if (!s_q.runSigned) begin
                macRes = 32'hffffffff;
            end else if (macSum[33]) begin
                macRes = 32'h80000000;
            end else begin
                macRes = 32'h7fffffff;
            end
        end
    end

    // ****************************************
    // Divide operand preparation
    // ****************************************
    // The launch write still carries the top divisor byte on the bus,
    // so the divisor takes that byte, not the stale stored one
    assign opBNow = (regWrite && regIndex == `MDC_IDX_OPTOP) ? regWdata : s_q.opB[15:8];

    // Divisor: 16 bit from opB, or 32 bit from opB high and opA low
    always_comb begin
        divisorRaw = {16'h0000, opBNow, s_q.opB[7:0]};
        if (calcSelect == MDC_DIV32) begin
            divisorRaw = {opBNow, s_q.opB[7:0], s_q.opA[15:0]};
        end else if (signedSet) begin
            divisorRaw = {{16{opBNow[7]}}, opBNow, s_q.opB[7:0]};
        end
    end

    // Dividend is whatever the result registers hold at launch
    always_comb begin
        divDividend = s_q.res;
        divDivisor = divisorRaw;
        // Divider works on magnitudes; signs are restored at writeback
        if (signedSet) begin
            if (s_q.res[31]) begin
                divDividend = 32'h0 - s_q.res;
            end
            if (divisorRaw[31]) begin
                divDivisor = 32'h0 - divisorRaw;
            end
        end
    end

    assign quoRes = s_q.negQuo ? 32'h0 - quoMag : quoMag;
    assign remRes = s_q.negRem ? 32'h0 - remMag : remMag;

    mdc_divider u_div (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .start(divStart),
        .dividend(divDividend),
        .divisor(divDivisor),
        .done(divDone),
        .quotient(quoMag),
        .remainder(remMag)
    );

    // Result and raw flags selected by the running mode
    always_comb begin
        finalRes = prod;
        fCarry = 1'b0;
        fOvf = 1'b0;
        fSat = 1'b0;
        case (s_q.runSel)
            MDC_MAC, MDC_MACSAT: begin
                finalRes = macRes;
                fCarry = macCarry;
                fOvf = macOvf;
                fSat = macSat;
            end
            MDC_DIV16, MDC_DIV32: begin
                finalRes = quoRes;
                fCarry = s_q.divZero;
                // Most negative by minus one overflows, as does divide by zero with a non-negative dividend
                fOvf = s_q.negQuo ? 1'b0 : quoMag[31];
            end
            default: begin
                finalRes = prod;
            end
        endcase
        fZero = (finalRes == 32'h0);
        fSign = finalRes[31];
    end

    mdc_flags u_flags (
        .calcSelect(s_q.runSel),
        .signedOp(s_q.runSigned),
        .flagsOld(s_q.status),
        .carry(fCarry),
        .zero(fZero),
        .sign(fSign),
        .ovf(fOvf),
        .sat(fSat),
        .flagsNew(flagsNew)
    );

    // ****************************************
    // Launch and sequencing
    // ****************************************
    // top operand byte launches
    assign launch = regWrite && regIndex == `MDC_IDX_OPTOP && s_q.state == MDC_IDLE &&
        s_q.setup[`MDC_SETUP_ALLOW] &&
        (calcSelect == MDC_MUL || calcSelect == MDC_DIV16 || calcSelect == MDC_MAC ||
         calcSelect == MDC_MACSAT || calcSelect == MDC_DIV32);
    assign divStart = launch && (calcSelect == MDC_DIV16 || calcSelect == MDC_DIV32);

    always_comb begin
        s_d = s_q;
        // ****************************************
        // Register writes
        // ****************************************
        if (regWrite) begin
            case (regIndex)
                `MDC_IDX_RES0: s_d.res[7:0] = regWdata;
                `MDC_IDX_RES1: s_d.res[15:8] = regWdata;
                `MDC_IDX_RES2: s_d.res[23:16] = regWdata;
                `MDC_IDX_RES3: s_d.res[31:24] = regWdata;
                `MDC_IDX_OPA0: s_d.opA[7:0] = regWdata;
                `MDC_IDX_OPA1: s_d.opA[15:8] = regWdata;
                `MDC_IDX_OPB0: s_d.opB[7:0] = regWdata;
                `MDC_IDX_OPTOP: s_d.opB[15:8] = regWdata;
                `MDC_IDX_SETUP: s_d.setup = regWdata;
                `MDC_IDX_STATUS: s_d.status = (regWdata & `MDC_STATUS_WMASK) |
                    (s_q.status & ~`MDC_STATUS_WMASK);
                default: s_d.rdata = s_q.rdata;
            endcase
        end
        // ****************************************
        // Calculation state machine
        // ****************************************
        case (s_q.state)
            MDC_IDLE: begin
                if (launch) begin
                    s_d.status[`MDC_BIT_BUSY] = 1'b1;
                    s_d.runSel = calcSelect;
                    s_d.runSigned = signedSet;
                    s_d.opB[15:8] = regWdata;
                    s_d.mulCnt = `MDC_MUL_CYCLES - 3'h1;
                    s_d.negQuo = signedSet && (s_q.res[31] != divisorRaw[31]);
                    s_d.negRem = signedSet && s_q.res[31];
                    s_d.divZero = (divisorRaw == 32'h0);
                    s_d.state = divStart ? MDC_DIVIDE : MDC_MULT;
                end
            end
            MDC_MULT: begin
                // Product settles at once; the count only paces writeback
                s_d.mulCnt = s_q.mulCnt - 3'h1;
                if (s_q.mulCnt == 3'h1) begin
                    // Writeback beats a status write in the same cycle
                    // busy falls at writeback
                    s_d.res = finalRes;
                    s_d.status = flagsNew;
                    s_d.state = MDC_IDLE;
                end
            end
            MDC_DIVIDE: begin
                if (divDone) begin
                    // Quotient to result, remainder to operand A
                    s_d.res = finalRes;
                    s_d.opA = remRes;
                    s_d.status = flagsNew;
                    s_d.state = MDC_IDLE;
                end
            end
            default: s_d.state = MDC_IDLE;
        endcase
        // ****************************************
        // Register reads
        // ****************************************
        if (regRead) begin
            // Read data holds until the next read strobe
            case (regIndex)
                `MDC_IDX_RES0: s_d.rdata = s_q.res[7:0];
                `MDC_IDX_RES1: s_d.rdata = s_q.res[15:8];
                `MDC_IDX_RES2: s_d.rdata = s_q.res[23:16];
                `MDC_IDX_RES3: s_d.rdata = s_q.res[31:24];
                `MDC_IDX_OPA0: s_d.rdata = s_q.opA[7:0];
                `MDC_IDX_OPA1: s_d.rdata = s_q.opA[15:8];
                `MDC_IDX_OPB0: s_d.rdata = s_q.opB[7:0];
                `MDC_IDX_OPTOP: s_d.rdata = s_q.opB[15:8];
                `MDC_IDX_SETUP: s_d.rdata = s_q.setup;
                `MDC_IDX_STATUS: s_d.rdata = s_q.status;
                `MDC_IDX_IDENT: s_d.rdata = `MDC_IDENT_VAL;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs, straight from the state register
    // ****************************************
    assign regRdata_q = s_q.rdata;
    assign calcBusy_q = s_q.status[`MDC_BIT_BUSY];
endmodule

// [hdl/mdc_consts.svh]
// Register indices, field positions, reset values and timing counts of the coprocessor
`ifndef MDC_CONSTS_SVH
`define MDC_CONSTS_SVH

`define MDC_IDX_RES0 4'h0
`define MDC_IDX_RES1 4'h1
`define MDC_IDX_RES2 4'h2
`define MDC_IDX_RES3 4'h3
`define MDC_IDX_OPA0 4'h4
`define MDC_IDX_OPA1 4'h5
`define MDC_IDX_OPB0 4'h6
`define MDC_IDX_OPTOP 4'h7
`define MDC_IDX_SETUP 4'h8
`define MDC_IDX_STATUS 4'h9
`define MDC_IDX_IDENT 4'hf

`define MDC_BIT_BUSY 0
`define MDC_BIT_SAT 3
`define MDC_BIT_OVF 4
`define MDC_BIT_SIGN 5
`define MDC_BIT_ZERO 6
`define MDC_BIT_CARRY 7
`define MDC_STATUS_WMASK 8'hfe
`define MDC_STATUS_RST 8'h00

`define MDC_SETUP_RST 8'h00
`define MDC_SETUP_ALLOW 7
`define MDC_SETUP_SIGNED 4

// Arbitrary identification value, not tied to any part
`define MDC_IDENT_VAL 8'h5a

`define MDC_MUL_CYCLES 3'h4
`define MDC_DIV_STEPS 6'h20
`endif

// [hdl/mdc_pkg.sv]
// Types shared by the coprocessor modules
package mdc_pkg;
    typedef enum logic [2:0] {
        MDC_MUL = 3'h0,
        MDC_DIV16 = 3'h1,
        MDC_MAC = 3'h2,
        MDC_MACSAT = 3'h3,
        MDC_DIV32 = 3'h5
    } mdc_calc_e;

    typedef enum logic [1:0] {
        MDC_IDLE,
        MDC_MULT,
        MDC_DIVIDE
    } mdc_state_e;
endpackage

// [hdl/mdc_flags.sv]
// Flag update selection per operation mode and sign setting
`timescale 1ns/10ps
`include "mdc_consts.svh"
module mdc_flags
    import mdc_pkg::*;
(
    input wire logic [2:0] calcSelect, // Operation mode
    input wire logic signedOp, // Signed arithmetic
    input wire logic [7:0] flagsOld, // Current status
    input wire logic carry, // Computed carry or div by zero
    input wire logic zero, // Result is zero
    input wire logic sign, // Result negative
    input wire logic ovf, // Two's range exceeded
    input wire logic sat, // Result clamped
    output logic [7:0] flagsNew // Updated status, busy cleared
);
    always_comb begin
        flagsNew = flagsOld;
        flagsNew[`MDC_BIT_BUSY] = 1'b0;
        case (calcSelect)
            MDC_MUL: begin
                flagsNew[`MDC_BIT_ZERO] = zero;
                if (signedOp) begin
                    flagsNew[`MDC_BIT_SIGN] = sign;
                end
            end
            MDC_DIV16, MDC_DIV32: begin
                flagsNew[`MDC_BIT_CARRY] = carry;
                flagsNew[`MDC_BIT_ZERO] = zero;
                if (signedOp) begin
                    flagsNew[`MDC_BIT_SIGN] = sign;
                    flagsNew[`MDC_BIT_OVF] = ovf;
                end
            end
            MDC_MAC, MDC_MACSAT: begin
                flagsNew[`MDC_BIT_CARRY] = carry;
                flagsNew[`MDC_BIT_ZERO] = zero;
                flagsNew[`MDC_BIT_SIGN] = sign;
                flagsNew[`MDC_BIT_OVF] = ovf;
                if (calcSelect == MDC_MACSAT && sat) begin
                    flagsNew[`MDC_BIT_SAT] = 1'b1;
                end
            end
            default: begin
                flagsNew = flagsOld;
                flagsNew[`MDC_BIT_BUSY] = 1'b0;
            end
        endcase
    end
endmodule

// [hdl/mdc_divider.sv]
// Restoring divider, one quotient bit per cycle, 32 bit dividend
`timescale 1ns/10ps
`include "mdc_consts.svh"
module mdc_divider
    import mdc_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic start, // Launch pulse
    input wire logic [31:0] dividend, // Magnitude of dividend
    input wire logic [31:0] divisor, // Magnitude of divisor
    output logic done, // One cycle when finished
    output logic [31:0] quotient, // Quotient magnitude
    output logic [31:0] remainder // Remainder magnitude
);
    typedef struct packed {
        logic [5:0] cnt;
        logic run;
        logic done;
        logic [31:0] quo;
        logic [32:0] rem;
        logic [31:0] dvs;
    } mdc_div_s;

    mdc_div_s s_q, s_d;
    logic [32:0] trial;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        trial = {s_q.rem[31:0], s_q.quo[31]} - {1'b0, s_q.dvs};
        if (start) begin
            s_d.run = 1'b1;
            s_d.cnt = `MDC_DIV_STEPS;
            s_d.quo = dividend;
            s_d.rem = 33'h0;
            s_d.dvs = divisor;
        end else if (s_q.run) begin
            if (trial[32]) begin
                s_d.rem = {s_q.rem[31:0], s_q.quo[31]};
                s_d.quo = {s_q.quo[30:0], 1'b0};
            end else begin
                s_d.rem = trial;
                s_d.quo = {s_q.quo[30:0], 1'b1};
            end
            s_d.cnt = s_q.cnt - 6'h1;
            if (s_q.cnt == 6'h1) begin
                s_d.run = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign quotient = s_q.quo;
    assign remainder = s_q.rem[31:0];
endmodule

// [testbench/mdc_coproc_properties.sv]
// Concurrent checks on the coprocessor register port
`timescale 1ns/10ps
`include "mdc_consts.svh"
module mdc_coproc_properties (
    input wire logic ref_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic regWrite, // Write strobe
    input wire logic regRead, // Read strobe
    input wire logic [3:0] regIndex, // Register number
    input wire logic [7:0] regWdata, // Write data
    input wire logic [7:0] regRdata_q, // Read data
    input wire logic calcBusy_q // Busy bit
);
    // ****************
    // Launch prediction
    // ****************
    logic [7:0] setupCopy_q;
    logic tryGo, goOk, goMul, goDiv, rdStat;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            setupCopy_q <= `MDC_SETUP_RST;
        end else if (regWrite && regIndex == `MDC_IDX_SETUP) begin
            setupCopy_q <= regWdata;
        end
    end
    // Shadow of setup, so launches are predicted from the port alone
    assign tryGo = regWrite && regIndex == `MDC_IDX_OPTOP && !calcBusy_q;
    assign goOk = tryGo && setupCopy_q[`MDC_SETUP_ALLOW]
        && setupCopy_q[2:0] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
    assign goDiv = goOk && setupCopy_q[1:0] == 2'h1;
    assign goMul = goOk && !goDiv;
    assign rdStat = regRead && regIndex == `MDC_IDX_STATUS;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence sMulRun;
        calcBusy_q [*3] ##[1:2] !calcBusy_q;
    endsequence
    sequence sDivRun;
        calcBusy_q [*8] ##[1:60] !calcBusy_q;
    endsequence
    sequence sStatWrRd;
        regWrite && regIndex == `MDC_IDX_STATUS && !calcBusy_q ##1 !regWrite ##1 rdStat;
    endsequence

    a_mul_busy_span: assert property (goMul |=> sMulRun)
        else $error("multiply busy span wrong");
    a_div_busy_span: assert property (goDiv |=> sDivRun)
        else $error("divide busy span wrong");
    a_busy_from_launch: assert property ($rose(calcBusy_q) |-> $past(goOk))
        else $error("busy rose without a launch");
    a_no_enable: assert property (tryGo && !setupCopy_q[7] |=> !calcBusy_q)
        else $error("launch while disabled");
    a_reserved_mode: assert property (tryGo && setupCopy_q[7] && !goOk |=> !calcBusy_q)
        else $error("reserved mode launched");
    a_busy_bit_read: assert property (rdStat |=> regRdata_q[0] == $past(calcBusy_q))
        else $error("status busy bit mismatch");
    a_ident_fixed: assert property (regRead && regIndex == `MDC_IDX_IDENT
        |=> regRdata_q == `MDC_IDENT_VAL) else $error("ident value wrong");
    a_reset_clear: assert property ($fell(sys_rst) |-> regRdata_q == 8'h00 && !calcBusy_q)
        else $error("outputs not cleared by reset");
    a_status_write: assert property (sStatWrRd
        |=> regRdata_q == ($past(regWdata, 3) & `MDC_STATUS_WMASK))
        else $error("status write readback wrong");
endmodule

bind mdc_coproc mdc_coproc_properties i_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .regWrite(regWrite), .regRead(regRead), .regIndex(regIndex), .regWdata(regWdata),
    .regRdata_q(regRdata_q), .calcBusy_q(calcBusy_q));

// [testbench/mdc_cpu_model.sv]
// Behavioural CPU issuing coprocessor register moves
`timescale 1ns/10ps
`include "mdc_consts.svh"
module mdc_cpu_model (
    input wire logic ref_clk, // Clock
    output logic regWrite, // Write strobe
    output logic regRead, // Read strobe
    output logic [3:0] regIndex, // Register number
    output logic [7:0] regWdata, // Write data
    input wire logic [7:0] regRdata_q, // Read data
    input wire logic calcBusy_q // Busy bit
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regIndex = 4'h0;
        regWdata = 8'h00;
    end

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regIndex <= idx;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        // Idle data lines never repeat the last value
        regWdata <= ~d;
    endtask

    task automatic rd(input logic [3:0] idx, output logic [7:0] d);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regIndex <= idx;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(negedge ref_clk);
        d = regRdata_q;
    endtask

    task automatic rd32(output logic [31:0] v);
        logic [7:0] b;
        for (int k = 0; k < 4; k++) begin
            rd(4'(k), b);
            v[8*k +: 8] = b;
        end
    endtask

    // setup written before the final operand byte
    // busy is sampled right after launch and again four clocks later
    task automatic calc(input logic [7:0] st, input logic [15:0] a, input logic [15:0] b,
        output logic [1:0] busySeen);
        wr(`MDC_IDX_SETUP, st);
        wr(`MDC_IDX_OPA0, a[7:0]);
        wr(`MDC_IDX_OPA1, a[15:8]);
        wr(`MDC_IDX_OPB0, b[7:0]);
        wr(`MDC_IDX_OPTOP, b[15:8]);
        #1;
        busySeen[1] = calcBusy_q;
        repeat (4) @(posedge ref_clk);
        #1;
        busySeen[0] = calcBusy_q;
        // A hang here is left to the bench watchdog
        while (calcBusy_q !== 1'b0) begin
            @(posedge ref_clk);
        end
    endtask
endmodule

// [testbench/muldiv_coprocessor_status_bench.sv]
// Self-checking bench for the coprocessor status and identification registers
`timescale 1ns/10ps
`include "mdc_consts.svh"
module muldiv_coprocessor_status_bench;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic regWrite, regRead, calcBusy_q;
    logic [3:0] regIndex;
    logic [7:0] regWdata, regRdata_q, rb;
    logic [31:0] rw;
    logic [1:0] bs;
    logic [7:0] noGo [5] = '{8'h00, 8'h03, 8'h84, 8'h86, 8'h87};
    int fail_count = 0;
    int n_compared = 0;

    always #4 ref_clk = ~ref_clk;

    mdc_coproc i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .regWrite(regWrite),
        .regRead(regRead), .regIndex(regIndex), .regWdata(regWdata),
        .regRdata_q(regRdata_q), .calcBusy_q(calcBusy_q));
    mdc_cpu_model i_cpu (.ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead),
        .regIndex(regIndex), .regWdata(regWdata), .regRdata_q(regRdata_q),
        .calcBusy_q(calcBusy_q));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rdck(input logic [3:0] idx, input logic [7:0] exp, input string what);
        i_cpu.rd(idx, rb);
        check(what, rb, exp);
    endtask

    task automatic give_verdict();
        $display("Compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        $display("Error watchdog expected end seen hang");
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdck(`MDC_IDX_STATUS, 8'h00, "status reset");
        rdck(`MDC_IDX_SETUP, 8'h00, "setup reset");
        i_cpu.wr(`MDC_IDX_IDENT, 8'ha5);
        rdck(`MDC_IDX_IDENT, `MDC_IDENT_VAL, "ident");
        rdck(4'ha, 8'h00, "unmapped read");
        i_cpu.wr(`MDC_IDX_STATUS, 8'hf9);
        rdck(`MDC_IDX_STATUS, 8'hf8, "busy write");
        $display("Test access done");
        i_cpu.calc(8'h80, 16'h1234, 16'haa55, bs);
        check("mul busy", bs, 2'b10);
        i_cpu.rd32(rw);
        check("umul product", rw, 32'h1234 * 32'haa55);
        rdck(`MDC_IDX_STATUS, 8'hb8, "umul flags");
        i_cpu.calc(8'h81, 16'h0000, 16'h1234, bs);
        i_cpu.rd32(rw);
        check("udiv quotient", rw, 32'h0000aa55);
        rdck(`MDC_IDX_STATUS, 8'h38, "udiv flags");
        i_cpu.wr(`MDC_IDX_STATUS, 8'h00);
        i_cpu.calc(8'h90, 16'h1234, 16'haa55, bs);
        i_cpu.rd32(rw);
        check("smul product", rw, 32'h0 - 32'h1234 * 32'h55ab);
        rdck(`MDC_IDX_STATUS, 8'h20, "smul flags");
        i_cpu.calc(8'h80, 16'h0000, 16'h0007, bs);
        rdck(`MDC_IDX_STATUS, 8'h60, "zero flags");
        $display("Test multiply and divide done");
        i_cpu.wr(`MDC_IDX_STATUS, 8'hf8);
        i_cpu.calc(8'h82, 16'h0002, 16'h0003, bs);
        i_cpu.rd32(rw);
        check("mac sum", rw, 32'h6);
        rdck(`MDC_IDX_STATUS, 8'h08, "mac flags");
        i_cpu.wr(`MDC_IDX_STATUS, 8'h00);
        repeat (3) i_cpu.calc(8'h93, 16'h7fff, 16'h7fff, bs);
        i_cpu.rd32(rw);
        check("sat clamp", rw, 32'h7fffffff);
        i_cpu.rd(`MDC_IDX_STATUS, rb);
        check("sat flag", rb & 8'h28, 8'h08);
        check("sat overflow", rb & 8'h10, 8'h10);
        i_cpu.calc(8'h80, 16'h0000, 16'h0000, bs);
        i_cpu.rd(`MDC_IDX_STATUS, rb);
        check("sat sticky", rb & 8'h48, 8'h48);
        i_cpu.wr(`MDC_IDX_STATUS, 8'h00);
        i_cpu.calc(8'h95, 16'h0003, 16'h0000, bs);
        rdck(`MDC_IDX_STATUS, 8'h40, "sdiv32 flags");
        i_cpu.calc(8'h81, 16'h0000, 16'h0000, bs);
        i_cpu.rd(`MDC_IDX_STATUS, rb);
        check("div zero carry", rb & 8'h80, 8'h80);
        i_cpu.wr(`MDC_IDX_STATUS, 8'h00);
        for (int k = 0; k < 4; k++) i_cpu.wr(4'(k), (k == 0) ? 8'h9c : 8'hff);
        i_cpu.calc(8'h91, 16'h0000, 16'h0007, bs);
        i_cpu.rd32(rw);
        check("sdiv quotient", rw, 32'hfffffff2);
        rdck(`MDC_IDX_STATUS, 8'h20, "sdiv flags");
        $display("Test accumulate and flags done");
        foreach (noGo[k]) begin
            i_cpu.wr(`MDC_IDX_SETUP, noGo[k]);
            i_cpu.wr(`MDC_IDX_OPTOP, 8'h01);
            @(negedge ref_clk);
            check("no launch", calcBusy_q, 1'b0);
        end
        i_cpu.wr(`MDC_IDX_SETUP, 8'h81);
        i_cpu.wr(`MDC_IDX_OPB0, 8'h03);
        i_cpu.wr(`MDC_IDX_OPTOP, 8'h00);
        i_cpu.wr(`MDC_IDX_SETUP, 8'h01);
        @(negedge ref_clk);
        check("disabled mid run", calcBusy_q, 1'b1);
        repeat (60) @(posedge ref_clk);
        i_cpu.wr(`MDC_IDX_OPTOP, 8'h00);
        @(negedge ref_clk);
        check("no relaunch", calcBusy_q, 1'b0);
        $display("Test enable and modes done");
        give_verdict();
    end
endmodule
